// ===== qcef_fifo.sv
// quad channel input elastic fifo with sync-driven pointer resets
`timescale 1ns/1ps
`include "qcef_map.svh"
module qcef_fifo
  import qcef_pkg::*;
#(
  parameter int DEPTH = `QCEF_DEPTH
)
(
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  // input_ddr_clock edge enables, one cycle each
  input  wire logic                        IN_RISE_EN,
  input  wire logic                        IN_FALL_EN,
  // ddr data and syncs from the source
  input  wire logic [`QCEF_HALF_W-1:0]     IN_DATA,
  input  wire logic                        INPUT_STROBE,
  input  wire logic                        SYNC_PIN,
  input  wire logic                        SIF_SYNC,
  input  wire logic                        OUTPUT_STROBE,
  // configuration
  input  wire logic                        FIFO_ENA,
  input  wire logic [`QCEF_SEL_W-1:0]      SEL_FIFOIN,
  input  wire logic [`QCEF_SEL_W-1:0]      SEL_FIFOOUT,
  input  wire logic [`QCEF_PTR_W-1:0]      FIFO_OFFSET,
  input  wire logic [`QCEF_INTERP_W-1:0]   INTERP,
  // sample output stream
  output logic [`QCEF_SAMPLE_W-1:0]        OUT_DATA,
  output logic                             OUT_VALID,
  input  wire logic                        OUT_READY,
  // status
  output logic [1:0]                       MODE,
  output logic [`QCEF_PTR_W-1:0]           WR_PTR,
  output logic [`QCEF_PTR_W-1:0]           RD_PTR,
  output logic                             ALARM_COLLIDE,
  output logic                             ALARM_ONE_AWAY,
  output logic                             ALARM_TWO_AWAY
);

  // depth is tied to the 3-bit pointers and the modulo-eight alarm gap
  if (DEPTH != `QCEF_DEPTH)
  begin : g_depth_chk
    $error("qcef_fifo: depth must be eight");
  end

  // storage: eight 64-bit sample locations
  logic [`QCEF_SAMPLE_W-1:0] mem_ff [DEPTH];

  // write side, paced by input_ddr_clock edge enables
  logic [`QCEF_HALF_W-1:0]  rise_half_ff;
  logic [`QCEF_PTR_W-1:0]   wr_ptr_ff;
  logic                     sync_in_ff;
  logic                     sync_in_q_ff;
  logic                     wr_rst_req_ff;
  logic                     wr_tog_ff;
  logic [`QCEF_SAMPLE_W-1:0] byp_word_ff;
  logic                     byp_new_ff;
  logic                     sif_ff;

  // selected write-side sync level
  wire wr_sel_level = (SEL_FIFOIN[`QCEF_SEL_ISTRB] & INPUT_STROBE)
                    | (SEL_FIFOIN[`QCEF_SEL_PIN] & SYNC_PIN);
  wire sif_rise     = SIF_SYNC & ~sif_ff;
  // serial sync is a register event, so it is taken on any cycle
  wire wr_sync_rise = (IN_RISE_EN & wr_sel_level & ~sync_in_ff)
                    | (SEL_FIFOIN[`QCEF_SEL_SIF] & sif_rise);
  wire [`QCEF_SAMPLE_W-1:0] full_word = {IN_DATA, rise_half_ff};
  wire [`QCEF_PTR_W-1:0] nxt_wr_ptr =
    wr_sync_rise ? `QCEF_WR_RST_LOC : wr_ptr_ff + 3'h1;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rise_half_ff <= '0;
      wr_ptr_ff    <= `QCEF_WR_RST_LOC;
      sync_in_ff   <= 1'b0;
    end
    else
    begin
      if (IN_RISE_EN)
      begin
        rise_half_ff <= IN_DATA;
        sync_in_ff   <= wr_sel_level;
      end
      if (wr_sync_rise)
        wr_ptr_ff <= `QCEF_WR_RST_LOC;
      else if (IN_FALL_EN && FIFO_ENA)
        wr_ptr_ff <= nxt_wr_ptr;
    end
  end

  // memory write on falling edge when the sample is complete
  always_ff @(posedge CLK)
  begin
    if (IN_FALL_EN && FIFO_ENA)
      mem_ff[wr_ptr_ff] <= full_word;
  end

  // bypass capture and write-side sync event toggle
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      byp_word_ff <= '0;
      byp_new_ff  <= 1'b0;
      wr_tog_ff   <= 1'b0;
    end
    else
    begin
      byp_new_ff <= IN_FALL_EN & ~FIFO_ENA;
      if (IN_FALL_EN && !FIFO_ENA)
        byp_word_ff <= full_word;
      if (wr_sync_rise)
        wr_tog_ff <= ~wr_tog_ff;
    end
  end

  // read side: sync resample, output strobe sampling, read strobe
  logic                     tog_s1_ff;
  logic                     tog_s2_ff;
  logic                     tog_s3_ff;
  logic                     out_strb_ff;
  logic [`QCEF_INTERP_W-1:0] div_ff;
  logic [`QCEF_PTR_W-1:0]   rd_ptr_ff;

  // two-stage resample of the write-side sync event toggle
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_s3_ff <= 1'b0;
      out_strb_ff <= 1'b0;
      sif_ff    <= 1'b0;
    end
    else
    begin
      tog_s1_ff <= wr_tog_ff;
      tog_s2_ff <= tog_s1_ff;
      tog_s3_ff <= tog_s2_ff;
      out_strb_ff <= OUTPUT_STROBE;
      sif_ff    <= SIF_SYNC;
    end
  end

  wire wr_sync_rd   = tog_s2_ff ^ tog_s3_ff;
  wire out_strb_rise = OUTPUT_STROBE & ~out_strb_ff;
  // input strobe or pin chosen for the read side uses the resampled event
  wire rd_in_sel    = SEL_FIFOOUT[`QCEF_SEL_ISTRB]
                    | SEL_FIFOOUT[`QCEF_SEL_PIN];
  wire rd_sync      = (SEL_FIFOOUT[`QCEF_SEL_OSTRB] & out_strb_rise)
                    | (SEL_FIFOOUT[`QCEF_SEL_SIF] & sif_rise)
                    | (rd_in_sel & wr_sync_rd);
  wire sel_none     = (SEL_FIFOIN == 4'h0) && (SEL_FIFOOUT == 4'h0);

  wire mode_dual    = SEL_FIFOOUT == 4'h4;
  wire mode_single  = !SEL_FIFOOUT[`QCEF_SEL_OSTRB]
                    && !SEL_FIFOOUT[`QCEF_SEL_SIF] && rd_in_sel;

  // read strobe: conversion clock divided by interpolation factor
  wire interp_one   = INTERP <= 5'h01;
  wire rd_tick      = interp_one || (div_ff == INTERP - 5'h01);
  wire buf_ready;
  wire rd_fire      = rd_tick & buf_ready & FIFO_ENA;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      div_ff <= '0;
    else if (rd_tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 5'h01;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rd_ptr_ff <= `QCEF_RD_OFS_RST;
    else if (rd_sync && !sel_none)
      rd_ptr_ff <= FIFO_OFFSET;
    else if (rd_fire)
      rd_ptr_ff <= rd_ptr_ff + 3'h1;
  end

  // two-entry output buffer so a receiver stall loses no word when the fifo is enabled; bypass words arriving while it is full are dropped
  logic [`QCEF_SAMPLE_W-1:0] ent_ff [2];
  logic [1:0]                cnt_ff;
  logic                      head_ff;
  wire  src_valid  = FIFO_ENA ? rd_fire : byp_new_ff;
  wire [`QCEF_SAMPLE_W-1:0] src_data =
    FIFO_ENA ? mem_ff[rd_ptr_ff] : byp_word_ff;
  assign buf_ready = cnt_ff != 2'h2;
  wire  push = src_valid & buf_ready;
  wire  pop  = OUT_VALID & OUT_READY;
  wire  tail = head_ff ^ cnt_ff[0];

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cnt_ff  <= 2'h0;
      head_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= cnt_ff + {1'b0, push} - {1'b0, pop};
      if (pop)
        head_ff <= ~head_ff;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (push)
      ent_ff[tail] <= src_data;
  end

  assign OUT_VALID = cnt_ff != 2'h0;
  assign OUT_DATA  = ent_ff[head_ff];

  // alarms from the modulo-eight pointer gap, read domain
  wire [`QCEF_PTR_W-1:0] gap = wr_ptr_ff - rd_ptr_ff;
  logic col_ff;
  logic one_ff;
  logic two_ff;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      col_ff <= 1'b0;
      one_ff <= 1'b0;
      two_ff <= 1'b0;
    end
    else
    begin
      col_ff <= FIFO_ENA & (gap == 3'h0);
      one_ff <= FIFO_ENA & (gap == 3'h1 || gap == 3'h7);
      two_ff <= FIFO_ENA & (gap == 3'h2 || gap == 3'h6);
    end
  end

  assign ALARM_COLLIDE  = col_ff;
  assign ALARM_ONE_AWAY = one_ff;
  assign ALARM_TWO_AWAY = two_ff;
  assign WR_PTR         = wr_ptr_ff;
  assign RD_PTR         = rd_ptr_ff;
  assign MODE = !FIFO_ENA   ? QCEF_BYPASS :
                mode_dual   ? QCEF_DUAL   :
                mode_single ? QCEF_SINGLE : QCEF_OTHER;

  // checks: write side
  AST_WR_RESET: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    wr_sync_rise |=> wr_ptr_ff == 3'h0)
    else $error("write pointer not reset by sync");
  AST_WR_ADV: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    IN_FALL_EN && FIFO_ENA && !wr_sync_rise
      |=> wr_ptr_ff == $past(wr_ptr_ff) + 3'h1)
    else $error("write pointer did not advance");
  AST_WR_HOLD: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !IN_FALL_EN && !wr_sync_rise |=> $stable(wr_ptr_ff))
    else $error("write pointer moved without a write");
  AST_MEM_WRITE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    IN_FALL_EN && FIFO_ENA
      |=> mem_ff[$past(wr_ptr_ff)] == $past(full_word))
    else $error("sample not stored at write pointer");
  AST_SYNC_SAMPLE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !IN_RISE_EN |=> $stable(sync_in_ff))
    else $error("input sync sampled off a rising edge");

  // checks: read side and sync source selection
  AST_RD_RESET: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    rd_sync && !sel_none |=> rd_ptr_ff == $past(FIFO_OFFSET))
    else $error("read pointer not at offset");
  AST_RD_ADV: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    rd_fire && !(rd_sync && !sel_none)
      |=> rd_ptr_ff == $past(rd_ptr_ff) + 3'h1)
    else $error("read pointer did not advance");
  AST_RD_REFUSE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    rd_tick && !buf_ready && !rd_sync |=> $stable(rd_ptr_ff))
    else $error("read pointer moved on a refused read");
  AST_RD_PACE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    INTERP > 5'h01 && rd_tick
      |=> !rd_tick || INTERP != $past(INTERP))
    else $error("read strobe faster than interpolation");
  AST_NO_RESET: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    sel_none && !rd_fire |=> $stable(rd_ptr_ff))
    else $error("read pointer moved with syncs disabled");
  AST_NO_WR_RESET: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    SEL_FIFOIN == 4'h0 && !IN_FALL_EN |=> $stable(wr_ptr_ff))
    else $error("write pointer moved with syncs disabled");
  AST_OUT_STROBE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    SEL_FIFOOUT == 4'h4 && OUTPUT_STROBE && !out_strb_ff
      |=> rd_ptr_ff == $past(FIFO_OFFSET))
    else $error("output strobe missed");
  AST_XSYNC: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    wr_sync_rise && SEL_FIFOOUT == 4'h2 && !sel_none
      |-> ##3 rd_sync)
    else $error("resampled sync late");
  AST_DUAL: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    mode_dual && !out_strb_rise && !rd_fire
      |=> $stable(rd_ptr_ff))
    else $error("read pointer moved by write sync in dual mode");
  AST_SINGLE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    FIFO_ENA && mode_single && wr_sync_rd
      |=> rd_ptr_ff == $past(FIFO_OFFSET))
    else $error("single source sync missed read pointer");
  AST_SIF_BOTH: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    SEL_FIFOIN == 4'h8 && SEL_FIFOOUT == 4'h8 && sif_rise
      |=> wr_ptr_ff == 3'h0 && rd_ptr_ff == $past(FIFO_OFFSET))
    else $error("serial sync did not reset both pointers");

  // checks: alarms, bypass and output buffer
  AST_COLLIDE: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    FIFO_ENA && wr_ptr_ff == rd_ptr_ff |=> ALARM_COLLIDE)
    else $error("collision alarm missing");
  AST_ONE_AWAY: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    FIFO_ENA && (gap == 3'h1 || gap == 3'h7) |=> ALARM_ONE_AWAY)
    else $error("one away alarm missing");
  AST_TWO_AWAY: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    FIFO_ENA && (gap == 3'h2 || gap == 3'h6) |=> ALARM_TWO_AWAY)
    else $error("two away alarm missing");
  AST_BYPASS: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !FIFO_ENA
      |=> !ALARM_COLLIDE && !ALARM_ONE_AWAY && !ALARM_TWO_AWAY)
    else $error("alarm in bypass");
  AST_BYP_DATA: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    IN_FALL_EN && !FIFO_ENA
      |=> byp_new_ff && byp_word_ff == $past(full_word))
    else $error("bypass sample not captured");
  AST_NOLOSS: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output word lost under stall");

endmodule

// ===== qcef_map.svh
// offsets, field widths and reset values of the elastic fifo
`ifndef QCEF_MAP_SVH
`define QCEF_MAP_SVH
`define QCEF_DEPTH        8
`define QCEF_PTR_W        3
`define QCEF_CH_W         16
`define QCEF_HALF_W       32
`define QCEF_SAMPLE_W     64
`define QCEF_SEL_W        4
`define QCEF_WR_RST_LOC   3'h0
`define QCEF_RD_OFS_RST   3'h4
`define QCEF_SEL_SIF      3
`define QCEF_SEL_OSTRB    2
`define QCEF_SEL_ISTRB    1
`define QCEF_SEL_PIN      0
`define QCEF_INTERP_W     5
`endif

// ===== qcef_pkg.sv
// types of the quad channel input elastic fifo
package qcef_pkg;
  typedef enum logic [1:0] {QCEF_BYPASS, QCEF_DUAL, QCEF_SINGLE, QCEF_OTHER}
    qcef_mode_t;
endpackage

// ===== qcef_src.sv
// behavioural ddr sample source feeding the elastic fifo
`timescale 1ns/1ps
module qcef_src
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // bench request for a sync pulse
  input  wire logic        sync_on,
  // ddr bus towards the fifo
  output logic             rise_en,
  output logic             fall_en,
  output logic [31:0]      data,
  output logic             sync
);
  logic [1:0]  ph_ff;
  logic [15:0] k_ff;
  // one sample per four cycles; idle cycles toggle the bus so stale
  // values are never mistaken for data
  always @(negedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph_ff   <= 2'h0;
      k_ff    <= 16'h0;
      rise_en <= 1'b0;
      fall_en <= 1'b0;
      data    <= 32'h0;
      sync    <= 1'b0;
    end
    else
    begin
      ph_ff   <= ph_ff + 2'h1;
      rise_en <= (ph_ff == 2'h0);
      fall_en <= (ph_ff == 2'h2);
      if (ph_ff == 2'h0)
      begin
        data <= {16'hA000, k_ff};
        sync <= sync_on && (k_ff[2:0] == 3'h0);
      end
      else if (ph_ff == 2'h2)
      begin
        data <= {16'h5000, k_ff};
        k_ff <= k_ff + 16'h1;
      end
      else
        data <= ~data;
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench of the quad channel input elastic fifo
`timescale 1ns/1ps
module testbench;
  import qcef_pkg::*;
  logic        CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        rise_en, fall_en, sync, sync_on = 1'b0;
  logic [31:0] in_data;
  logic        SIF_SYNC = 1'b0, OUTPUT_STROBE = 1'b0, FIFO_ENA = 1'b1;
  logic [3:0]  SEL_FIFOIN = 4'h1, SEL_FIFOOUT = 4'h4;
  logic [2:0]  FIFO_OFFSET = 3'h4;
  logic [4:0]  INTERP = 5'h04;
  logic        OUT_READY = 1'b1, OUT_VALID, ALARM_COLLIDE, ALARM_ONE_AWAY;
  logic        ALARM_TWO_AWAY, chk_on = 1'b0, al_on = 1'b0, seen = 1'b0;
  logic        strobe_path = 1'b0;
  logic [63:0] OUT_DATA, hold;
  logic [1:0]  MODE;
  logic [2:0]  WR_PTR, RD_PTR, pw, pr, d;
  logic [15:0] last_k;
  int          bad_count = 0, n_compared = 0, warm = 0;
  // rows: fifo enable, read select, expected mode
  localparam logic [6:0] MROW [6] = '{{1'b0, 4'h4, 2'h0}, {1'b1, 4'h4, 2'h1},
    {1'b1, 4'h1, 2'h2}, {1'b1, 4'h2, 2'h2}, {1'b1, 4'h3, 2'h2},
    {1'b1, 4'h8, 2'h3}};
  // rows: write select, read select, offset, trigger kind
  localparam logic [12:0] TROW [4] = '{{4'h1, 4'h4, 3'h2, 2'h0},
    {4'h1, 4'h1, 3'h5, 2'h1}, {4'h2, 4'h2, 3'h6, 2'h1},
    {4'h8, 4'h8, 3'h3, 2'h2}};

  always #5 CLK = ~CLK;

  qcef_src i_qcef_src (.clk(CLK), .arst_n(ARST_N), .sync_on(sync_on),
    .rise_en(rise_en), .fall_en(fall_en), .data(in_data), .sync(sync));

  qcef_fifo i_qcef_fifo (.CLK(CLK), .ARST_N(ARST_N), .IN_RISE_EN(rise_en),
    .IN_FALL_EN(fall_en), .IN_DATA(in_data),
    .INPUT_STROBE(sync & strobe_path), .SYNC_PIN(sync & ~strobe_path),
    .SIF_SYNC(SIF_SYNC), .OUTPUT_STROBE(OUTPUT_STROBE),
    .FIFO_ENA(FIFO_ENA), .SEL_FIFOIN(SEL_FIFOIN), .SEL_FIFOOUT(SEL_FIFOOUT),
    .FIFO_OFFSET(FIFO_OFFSET), .INTERP(INTERP), .OUT_DATA(OUT_DATA),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .MODE(MODE),
    .WR_PTR(WR_PTR), .RD_PTR(RD_PTR), .ALARM_COLLIDE(ALARM_COLLIDE),
    .ALARM_ONE_AWAY(ALARM_ONE_AWAY), .ALARM_TWO_AWAY(ALARM_TWO_AWAY));

  task automatic chk(input string nm, input logic [63:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic rst_chk;
    ARST_N = 1'b0;
    FIFO_OFFSET = 3'h4;
    repeat (10) @(negedge CLK);
    chk("wr_ptr", 3'h0, WR_PTR);
    chk("rd_ptr", 3'h4, RD_PTR);
    chk("out_valid", 1'b0, OUT_VALID);
    chk("alarms", 3'h0, {ALARM_COLLIDE, ALARM_ONE_AWAY, ALARM_TWO_AWAY});
    ARST_N = 1'b1;
    $display("test reset done");
  endtask

  // pulse a sync source, then both pointers must land on their homes
  task automatic trig(input logic [12:0] r);
    int   i;
    logic wr_ok, rd_ok;
    {SEL_FIFOIN, SEL_FIFOOUT, FIFO_OFFSET} = r[12:2];
    strobe_path = r[10];
    chk_on = 1'b0;
    @(negedge CLK);
    SIF_SYNC = (r[1:0] == 2'h2);
    sync_on = (r[1:0] != 2'h2);
    i = 0;
    while (sync_on && !(rise_en && sync) && i < 64)
    begin
      @(posedge CLK);
      i++;
    end
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    for (i = 0; i < 12; i++)
    begin
      @(negedge CLK);
      OUTPUT_STROBE = (i == 0) && (r[1:0] == 2'h0);
      {SIF_SYNC, sync_on} = 2'h0;
      wr_ok |= (WR_PTR === 3'h0);
      rd_ok |= (RD_PTR === r[4:2]);
    end
    chk("wr_reset", 1'b1, wr_ok);
    chk("rd_reset", 1'b1, rd_ok);
    warm = 0;
  endtask

  // stream monitor: after the first nine, every accepted word pairs its halves and follows on
  always @(posedge CLK)
  begin
    if (ARST_N && chk_on && OUT_VALID === 1'b1 && OUT_READY === 1'b1)
    begin
      if (warm > 8)
      begin
        chk("pairing", {16'h5000, OUT_DATA[15:0], 16'hA000, OUT_DATA[15:0]}, OUT_DATA);
        chk("order", last_k + 16'h1, OUT_DATA[15:0]);
      end
      last_k = OUT_DATA[15:0];
      warm++;
    end
  end

  // alarm monitor: alarm follows the pointer gap of the previous cycle
  always @(negedge CLK)
  begin
    d = pw - pr;
    if (al_on)
    begin
      chk("collide", d == 3'h0, ALARM_COLLIDE);
      chk("one_away", d == 3'h1 || d == 3'h7, ALARM_ONE_AWAY);
      chk("two_away", d == 3'h2 || d == 3'h6, ALARM_TWO_AWAY);
      seen |= ALARM_COLLIDE;
    end
    pw = WR_PTR;
    pr = RD_PTR;
  end

  initial
  begin
    #50000;
    bad_count++;
    $display("watchdog expired");
    conclude;
  end

  initial
  begin
    rst_chk;
    foreach (MROW[i])
    begin
      @(negedge CLK);
      {FIFO_ENA, SEL_FIFOOUT} = MROW[i][6:2];
      #1 chk("mode", MROW[i][1:0], MODE);
    end
    $display("test modes done");
    {FIFO_ENA, SEL_FIFOIN, SEL_FIFOOUT} = {1'b1, 4'h1, 4'h4};
    chk_on = 1'b1;
    repeat (200) @(negedge CLK);
    chk("stream_seen", 1'b1, warm > 12);
    OUT_READY = 1'b0;
    repeat (8) @(negedge CLK);
    hold = OUT_DATA;
    chk("stall_valid", 1'b1, OUT_VALID);
    repeat (8) @(negedge CLK);
    chk("stall_held", 1'b1, OUT_VALID);
    chk("stall_data", hold, OUT_DATA);
    OUT_READY = 1'b1;
    repeat (80) @(negedge CLK);
    $display("test stream and stall done");
    foreach (TROW[i])
      trig(TROW[i]);
    $display("test pointer resets done");
    FIFO_ENA = 1'b0;
    chk_on = 1'b1;
    repeat (120) @(negedge CLK);
    chk("bypass_seen", 1'b1, warm > 12);
    $display("test bypass done");
    {chk_on, FIFO_ENA, INTERP} = {1'b0, 1'b1, 5'h03};
    @(negedge CLK);
    al_on = 1'b1;
    repeat (400) @(negedge CLK);
    chk("collide_seen", 1'b1, seen);
    al_on = 1'b0;
    $display("test alarms done");
    rst_chk;
    conclude;
  end
endmodule
